// ---- shared/dpc_pkg.sv ----
package dpc_pkg;
   localparam int CLK_MHZ = 50;
   // host-side timing figures in ns (slower speed grade)
   localparam int T_READ_ACCESS_NS = 20;   // address / chip enable access
   localparam int T_OE_ACCESS_NS   = 12;
   localparam int T_CONTENTION_NS  = 17;   // contention_release_to_data
   localparam int T_WRITE_PULSE_NS = 15;
   localparam int T_WZ_NS          = 10;   // write enable to output float
   localparam int T_OW_NS          = 0;    // output active from end of write
   localparam int T_RECOVERY_NS    = 0;
   localparam int T_FLAG_W2R_NS    = 5;
   // least times round up, never below one cycle
   function automatic int min_cycles(input int ns);
      int c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int READ_CYC     = min_cycles(T_READ_ACCESS_NS);
   localparam int OE_CYC       = min_cycles(T_OE_ACCESS_NS);
   localparam int CONT_CYC     = min_cycles(T_CONTENTION_NS);
   localparam int WP_CYC       = min_cycles(T_WRITE_PULSE_NS);
   localparam int WP_OE_CYC    = min_cycles(T_WZ_NS + T_OW_NS);
   localparam int REC_CYC      = min_cycles(T_RECOVERY_NS);
   localparam int FLAG_W2R_CYC = min_cycles(T_FLAG_W2R_NS);
   localparam int CNT_W        = 4;
   localparam int ADDR_W       = 16;
   localparam int DATA_W       = 16;
   localparam int FLAG_ADDR_W  = 3;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   typedef enum logic [1:0] {DPC_OP_RD, DPC_OP_WR, DPC_OP_FRD, DPC_OP_FWR} dpc_op_t;
endpackage

// ---- core/dpc_wait_timer.sv ----
`timescale 1ns/1ps
module dpc_wait_timer #(
   parameter int W = 4
) (
   input  wire logic         clk,    // system clock
   input  wire logic         rstn,   // sync reset, active low
   input  wire logic         load,   // start a count
   input  wire logic [W-1:0] count,  // cycles to wait
   output logic              done    // high while no count runs
);
   logic [W-1:0] left;
   // down counter; done means the loaded wait has elapsed
   always_ff @(posedge clk) begin
      if (!rstn) begin
         left <= '0;
      end else if (load) begin
         left <= count;
      end else if (left != '0) begin
         left <= left - 1'b1;
      end
   end
   // done must not look at load: the caller derives load from done
   assign done = (left == '0);
endmodule

// ---- core/dpc_host_port.sv ----
`timescale 1ns/1ps
module dpc_host_port
   import dpc_pkg::*;
(
   input  wire logic                      sys_clk,     // 50 MHz clock
   input  wire logic                      rstn,        // sync reset, active low
   input  wire logic                      reqValid,    // request pulse, taken when idle
   input  wire dpc_pkg::dpc_op_t          reqOp,       // read, write, flag read, flag write
   input  wire logic [dpc_pkg::ADDR_W-1:0] reqAddr,    // word address
   input  wire logic [dpc_pkg::DATA_W-1:0] reqData,    // write data
   input  wire logic [1:0]                reqBytes,    // [1] upper, [0] lower byte wanted
   input  wire logic                      reqSameAddr, // far port finishing write here
   output logic                           busy,        // transfer in progress
   output logic                           rspValid,    // one-cycle completion pulse
   output logic [dpc_pkg::DATA_W-1:0]     rspData,     // read result
   output logic                           portSelN,    // chip enable, low active
   output logic                           rwN,         // high read, low write
   output logic                           outEnableN,  // device output enable, low active
   output logic                           flag_select_n,      // flag access select
   output logic                           high_byte_select_n, // upper byte select
   output logic                           low_byte_select_n,  // lower byte select
   output logic [dpc_pkg::ADDR_W-1:0]     memAddr,     // address pins
   output logic [dpc_pkg::DATA_W-1:0]     dqOut,       // data driven to device
   output logic                           dqOeN,       // low while host drives data
   input  wire logic [dpc_pkg::DATA_W-1:0] dqIn        // data pins from device
);
   import dpc_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_READ, S_RECOV, S_GAP} dpc_state_t;
   dpc_state_t state;
   dpc_op_t    op;
   logic [DATA_W-1:0] dqMeta;
   logic [DATA_W-1:0] dqSync;
   logic              tLoad;
   logic [CNT_W-1:0]  tCount;
   logic              tDone;
   logic              lastFlagWr;

   function automatic logic isFlag(input dpc_op_t o);
      return (o == DPC_OP_FRD) || (o == DPC_OP_FWR);
   endfunction
   function automatic logic isWrite(input dpc_op_t o);
      return (o == DPC_OP_WR) || (o == DPC_OP_FWR);
   endfunction

   dpc_wait_timer #(.W(CNT_W)) uTimer (
      .clk   (sys_clk),
      .rstn  (rstn),
      .load  (tLoad),
      .count (tCount),
      .done  (tDone)
   );

   // pin data passes two flops before use
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         dqMeta <= DATA_RESET;
         dqSync <= DATA_RESET;
      end else begin
         dqMeta <= dqIn;
         dqSync <= dqMeta;
      end
   end

   // read wait: latest of the access delays, plus two sync stages
   function automatic logic [CNT_W-1:0] readWait(input logic sameAddr);
      int w;
      w = (READ_CYC > OE_CYC) ? READ_CYC : OE_CYC;
      if (sameAddr && CONT_CYC > w) w = CONT_CYC;
      return CNT_W'(w + 2);
   endfunction

   // timer loads per state entry
   always_comb begin
      tLoad  = 1'b0;
      tCount = '0;
      case (state)
         S_IDLE: begin
            if (reqValid) begin
               tLoad  = 1'b1;
               tCount = CNT_W'(1);
            end
         end
         S_SETUP: begin
            if (tDone) begin
               tLoad = 1'b1;
               if (isWrite(op)) begin
                  // output enable held high in writes, yet keep the wider pulse
                  tCount = CNT_W'((WP_CYC > WP_OE_CYC) ? WP_CYC : WP_OE_CYC);
               end else begin
                  tCount = readWait(reqSameAddr);
               end
            end
         end
         S_STROBE, S_READ: begin
            if (tDone) begin
               tLoad  = 1'b1;
               tCount = CNT_W'(REC_CYC);
            end
         end
         S_RECOV: begin
            if (tDone && lastFlagWr) begin
               tLoad  = 1'b1;
               tCount = CNT_W'(FLAG_W2R_CYC);
            end
         end
         default: begin
            tLoad  = 1'b0;
            tCount = '0;
         end
      endcase
   end

   // sequencing and pins
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state              <= S_IDLE;
         op                 <= DPC_OP_RD;
         busy               <= 1'b0;
         rspValid           <= 1'b0;
         rspData            <= DATA_RESET;
         portSelN           <= 1'b1;
         rwN                <= 1'b1;
         outEnableN         <= 1'b1;
         flag_select_n      <= 1'b1;
         high_byte_select_n <= 1'b1;
         low_byte_select_n  <= 1'b1;
         memAddr            <= ADDR_RESET;
         dqOut              <= DATA_RESET;
         dqOeN              <= 1'b1;
         lastFlagWr         <= 1'b0;
      end else begin
         rspValid <= 1'b0;
         case (state)
            S_IDLE: begin
               if (reqValid) begin
                  // all strobes high here, so the address may move
                  op      <= reqOp;
                  busy    <= 1'b1;
                  memAddr <= isFlag(reqOp) ? {{(ADDR_W-FLAG_ADDR_W){1'b0}}, reqAddr[FLAG_ADDR_W-1:0]}
                                           : reqAddr;
                  dqOut   <= (reqOp == DPC_OP_FWR) ? {{(DATA_W-1){1'b0}}, reqData[0]} : reqData;
                  if (isFlag(reqOp)) begin
                     portSelN           <= 1'b1;
                     flag_select_n      <= 1'b0;
                     high_byte_select_n <= 1'b1;
                     low_byte_select_n  <= 1'b1;
                  end else begin
                     portSelN           <= 1'b0;
                     flag_select_n      <= 1'b1;
                     high_byte_select_n <= ~reqBytes[1];
                     low_byte_select_n  <= ~reqBytes[0];
                  end
                  state <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (tDone) begin
                  if (isWrite(op)) begin
                     rwN   <= 1'b0;   // select already low, so outputs stay floating
                     dqOeN <= 1'b0;   // device outputs float with output enable high
                     state <= S_STROBE;
                  end else begin
                     outEnableN <= 1'b0;
                     state      <= S_READ;
                  end
               end
            end
            S_STROBE: begin
               if (tDone) begin
                  rwN        <= 1'b1; // ends the overlap, write commits
                  lastFlagWr <= (op == DPC_OP_FWR);
                  state      <= S_RECOV;
               end
            end
            S_READ: begin
               if (tDone) begin
                  // flag value repeats on every line; bit zero carries it
                  rspData    <= (op == DPC_OP_FRD) ? {DATA_W{dqSync[0]}} : dqSync;
                  outEnableN <= 1'b1;
                  lastFlagWr <= 1'b0;
                  state      <= S_RECOV;
               end
            end
            S_RECOV: begin
               if (tDone) begin
                  dqOeN              <= 1'b1; // data held past strobe rise for hold time
                  portSelN           <= 1'b1;
                  flag_select_n      <= 1'b1;
                  high_byte_select_n <= 1'b1;
                  low_byte_select_n  <= 1'b1;
                  rspValid           <= 1'b1;
                  busy               <= lastFlagWr;
                  state              <= lastFlagWr ? S_GAP : S_IDLE;
               end
            end
            S_GAP: begin
               // flag write to read spacing before the next request
               if (tDone) begin
                  busy       <= 1'b0;
                  lastFlagWr <= 1'b0;
                  state      <= S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// ---- dv/dpc_checker.sv ----
`timescale 1ns/1ps
module dpc_checker
   import dpc_pkg::*;
(
   input wire logic              sys_clk,       // clock
   input wire logic              rstn,          // sync reset
   input wire logic              busy,          // transfer running
   input wire logic              rspValid,      // done pulse
   input wire logic              portSelN,      // array select
   input wire logic              rwN,           // write strobe
   input wire logic              outEnableN,    // device output enable
   input wire logic              flag_select_n, // flag select
   input wire logic [ADDR_W-1:0] memAddr,       // address pins
   input wire logic [DATA_W-1:0] dqOut,         // host data
   input wire logic              dqOeN          // host drive enable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // strobe falls with host data already on the bus
   sequence s_strobe;
      $fell(rwN) ##0 !dqOeN;
   endsequence
   property p_sel_excl;
      (!rwN || !outEnableN) |-> (portSelN != flag_select_n);
   endproperty
   a_sel_excl: assert property (p_sel_excl) else $error("array and flag selects not exclusive");
   property p_sel_hold;
      (!rwN && $past(!rwN)) |-> $stable({portSelN, flag_select_n});
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("select moved during write");
   // select must lead the strobe, or the device floats its outputs
   property p_sel_first;
      $fell(rwN) |-> $past(!portSelN || !flag_select_n);
   endproperty
   a_sel_first: assert property (p_sel_first) else $error("strobe before select");
   property p_addr_hold;
      (!rwN || !outEnableN) |-> $stable(memAddr);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved in access");
   property p_no_fight;
      !dqOeN |-> outEnableN;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("host drives while device enabled");
   property p_pulse;
      s_strobe |-> !dqOeN[*2];
   endproperty
   a_pulse: assert property (p_pulse) else $error("write pulse or data hold short");
   property p_data_stable;
      (!rwN && $past(!rwN)) |-> $stable(dqOut);
   endproperty
   a_data_stable: assert property (p_data_stable) else $error("write data moved");
   property p_flag_sel;
      !flag_select_n |-> portSelN;
   endproperty
   a_flag_sel: assert property (p_flag_sel) else $error("array select in flag cycle");
   property p_done;
      $rose(busy) |-> ##[2:60] rspValid;
   endproperty
   a_done: assert property (p_done) else $error("transfer never completes");
   property p_pulse1;
      rspValid |=> !rspValid;
   endproperty
   a_pulse1: assert property (p_pulse1) else $error("done pulse too long");
   property p_idle;
      (!busy && $past(!busy)) |-> (portSelN && flag_select_n && rwN && outEnableN && dqOeN);
   endproperty
   a_idle: assert property (p_idle) else $error("pins active while idle");
endmodule
bind dpc_host_port dpc_checker chk (.sys_clk(sys_clk), .rstn(rstn), .busy(busy), .rspValid(rspValid),
   .portSelN(portSelN), .rwN(rwN), .outEnableN(outEnableN), .flag_select_n(flag_select_n),
   .memAddr(memAddr), .dqOut(dqOut), .dqOeN(dqOeN));

// ---- dv/dpc_sram_model.sv ----
`timescale 1ns/1ps
module dpc_sram_model
   import dpc_pkg::*;
(
   input wire logic          sys_clk,            // bench clock, for settle count
   input wire logic          portSelN,           // array select
   input wire logic          rwN,                // write strobe
   input wire logic          outEnableN,         // output enable
   input wire logic          flag_select_n,      // flag select
   input wire logic          high_byte_select_n, // upper byte
   input wire logic          low_byte_select_n,  // lower byte
   input wire logic [15:0]   memAddr,            // address
   input wire logic [15:0]   dqOut,              // host data
   output logic [15:0]       dqIn                // device data
);
   logic [15:0] mem [0:255];
   logic [7:0]  flag;
   logic [15:0] lastQ;
   logic [15:0] rdVal;
   logic        settled;
   logic        drive;
   initial begin
      flag = 8'h00;
      foreach (mem[i]) mem[i] = 16'h0000;
   end
   // commit at the end of the select/strobe overlap, bytes gated apart
   always @(posedge rwN) begin
      if (!portSelN && flag_select_n) begin
         if (!high_byte_select_n) mem[memAddr[7:0]][15:8] = dqOut[15:8];
         if (!low_byte_select_n) mem[memAddr[7:0]][7:0] = dqOut[7:0];
      end else if (portSelN && !flag_select_n) begin
         flag[memAddr[2:0]] = dqOut[0];
      end
   end
   // data only valid one cycle after the last enable; stands for every access delay
   always @(posedge sys_clk) begin
      settled <= !outEnableN && rwN;
      lastQ   <= dqIn;
   end
   // strobe low keeps outputs floating; floating shows a changing pattern
   always_comb begin
      rdVal = flag_select_n ? mem[memAddr[7:0]] : {16{flag[memAddr[2:0]]}};
      drive = !outEnableN && rwN && settled && (portSelN != flag_select_n);
      dqIn[15:8] = (drive && (!flag_select_n || !high_byte_select_n)) ? rdVal[15:8] : ~lastQ[15:8];
      dqIn[7:0]  = (drive && (!flag_select_n || !low_byte_select_n)) ? rdVal[7:0] : ~lastQ[7:0];
   end
endmodule

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
   import dpc_pkg::*;
   logic sys_clk, rstn, reqValid, reqSameAddr, busy, rspValid, portSelN, rwN, outEnableN;
   logic flag_select_n, high_byte_select_n, low_byte_select_n, dqOeN;
   logic [1:0]  reqBytes;
   logic [15:0] reqAddr, reqData, rspData, memAddr, dqOut, dqIn;
   dpc_op_t     reqOp;
   int          err_count, n_compared, cyc;
   logic [1:0]  op;
   logic [15:0] a, d, e;
   logic [1:0]  b;
   logic        s;
   // op, addr, data, bytes, same-address, expected read
   logic [52:0] rows [10] = '{
      {2'd1, 16'h0012, 16'h1234, 2'b11, 1'b0, 16'h0000}, {2'd0, 16'h0012, 16'h0000, 2'b11, 1'b0, 16'h1234},
      {2'd1, 16'h0012, 16'habcd, 2'b10, 1'b0, 16'h0000}, {2'd0, 16'h0012, 16'h0000, 2'b11, 1'b0, 16'hab34},
      {2'd1, 16'h0013, 16'h5a5a, 2'b01, 1'b0, 16'h0000}, {2'd0, 16'h0013, 16'h0000, 2'b11, 1'b1, 16'h005a},
      {2'd3, 16'h0003, 16'h0001, 2'b11, 1'b0, 16'h0000}, {2'd2, 16'h0003, 16'h0000, 2'b11, 1'b0, 16'hffff},
      {2'd2, 16'h000b, 16'h0000, 2'b11, 1'b0, 16'hffff}, {2'd2, 16'h0004, 16'h0000, 2'b11, 1'b0, 16'h0000}};
   dpc_host_port dut (.sys_clk(sys_clk), .rstn(rstn), .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
      .reqData(reqData), .reqBytes(reqBytes), .reqSameAddr(reqSameAddr), .busy(busy), .rspValid(rspValid),
      .rspData(rspData), .portSelN(portSelN), .rwN(rwN), .outEnableN(outEnableN), .flag_select_n(flag_select_n),
      .high_byte_select_n(high_byte_select_n), .low_byte_select_n(low_byte_select_n), .memAddr(memAddr),
      .dqOut(dqOut), .dqOeN(dqOeN), .dqIn(dqIn));
   dpc_sram_model mdl (.sys_clk(sys_clk), .portSelN(portSelN), .rwN(rwN), .outEnableN(outEnableN),
      .flag_select_n(flag_select_n), .high_byte_select_n(high_byte_select_n),
      .low_byte_select_n(low_byte_select_n), .memAddr(memAddr), .dqOut(dqOut), .dqIn(dqIn));
   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // poke holds the request up one more edge, which an busy port must ignore
   task automatic do_req(input logic [1:0] o, input logic [15:0] ad, input logic [15:0] dt,
                         input logic [1:0] by, input logic sa, input logic poke);
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 100) begin @(posedge sys_clk); #1; n++; end
      reqValid = 1'b1; reqOp = dpc_op_t'(o); reqAddr = ad; reqData = dt; reqBytes = by; reqSameAddr = sa;
      @(posedge sys_clk); #1;
      if (poke) begin reqData = ~dt; @(posedge sys_clk); #1; end
      reqValid = 1'b0;
      n = 0;
      while (rspValid !== 1'b1 && n < 100) begin @(posedge sys_clk); #1; n++; end
      if (n == 100) check(16'h0000, 16'h0001);
   endtask
   // hang guard, generous beside about 10 cycles a transfer
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin err_count++; wrap_up(); end
   end
   initial begin
      err_count = 0; n_compared = 0; cyc = 0;
      rstn = 1'b0; reqValid = 1'b0; reqOp = DPC_OP_RD; reqAddr = 16'h0000; reqData = 16'h0000;
      reqBytes = 2'b11; reqSameAddr = 1'b0;
      repeat (5) @(posedge sys_clk);
      #1 rstn = 1'b1;
      check({10'h000, portSelN, rwN, outEnableN, flag_select_n, dqOeN, busy}, 16'h003e);
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         {op, a, d, b, s, e} = rows[i];
         do_req(op, a, d, b, s, 1'b0);
         if (op == 2'd0 || op == 2'd2) check(rspData, e);
         $display("test row %0d done", i);
      end
      do_req(2'd1, 16'h0020, 16'h1111, 2'b11, 1'b0, 1'b1);
      do_req(2'd0, 16'h0020, 16'h0000, 2'b11, 1'b0, 1'b0);
      check(rspData, 16'h1111);
      $display("test busy request done");
      wrap_up();
   end
endmodule
